// ---- logic/prs_mem.sv ----
// prs_mem: single-port profile memory held in flip-flops.
// assumes the caller never asks for a read and a write in the same cycle.
`timescale 1ns/100ps
module prs_mem
   import prs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [9:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o,
   output logic rvalid_o
);
   logic [31:0] store [0:PRS_MEM_DEPTH-1];
   logic [31:0] next_rdata;
   logic next_rvalid;

   // array carries no reset: contents are undefined until loaded
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         store[addr_i] <= wdata_i;
      end
   end

   // write wins: a read asked for together with a write is dropped
   always_comb begin
      next_rdata = rdata_o;
      next_rvalid = 1'b0;
      if (re_i && !we_i) begin
         next_rdata = store[addr_i];
         next_rvalid = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
         rvalid_o <= 1'b0;
      end else begin
         rdata_o <= next_rdata;
         rvalid_o <= next_rvalid;
      end
   end
endmodule : prs_mem

// ---- logic/prs_pkg.sv ----
// prs_pkg: constants, types and decode helpers for the profile memory sweep block.
// assumes one 25 MHz clock that is also the dwell (sync) clock.
package prs_pkg;

   // memory geometry and field widths
   localparam int unsigned PRS_MEM_DEPTH = 1024;
   localparam int unsigned PRS_MEM_AW = 10;
   localparam int unsigned PRS_DW = 32;
   localparam int unsigned PRS_SER_DW = 40;
   localparam int unsigned PRS_REG_AW = 5;
   localparam int unsigned PRS_PHASE_W = 14;
   localparam int unsigned PRS_DWELL_W = 16;
   localparam int unsigned PRS_LOAD_W = 11;

   // clock
   localparam int unsigned PRS_CLK_PERIOD_NS = 40;

   // serial register addresses
   localparam logic [4:0] PRS_ADDR_CTRL = 5'h00;
   localparam logic [4:0] PRS_ADDR_FREQ = 5'h04;
   localparam logic [4:0] PRS_ADDR_PHASE = 5'h05;
   localparam logic [4:0] PRS_ADDR_SEG0 = 5'h07;
   localparam logic [4:0] PRS_ADDR_SEG1 = 5'h08;
   localparam logic [4:0] PRS_ADDR_SEG2 = 5'h09;
   localparam logic [4:0] PRS_ADDR_SEG3 = 5'h0a;
   localparam logic [4:0] PRS_ADDR_MEM = 5'h0b;

   // control word fields
   localparam int unsigned PRS_CTRL_MEM_EN_BIT = 31;
   localparam int unsigned PRS_CTRL_MEM_DEST_BIT = 30;

   // memory word bits used as phase
   localparam int unsigned PRS_MEM_PHASE_LSB = 18;

   // segment modes
   localparam logic [2:0] PRS_MODE_DIRECT = 3'h0;
   localparam logic [2:0] PRS_MODE_RAMP_UP = 3'h1;
   localparam logic [2:0] PRS_MODE_BIDIR = 3'h2;

   // reset values
   localparam logic [31:0] PRS_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PRS_FREQ_RST = 32'h0000_0000;
   localparam logic [13:0] PRS_PHASE_RST = 14'h0000;
   localparam logic [39:0] PRS_SEG_RST = 40'h00_0000_0000;
   localparam logic [15:0] PRS_DWELL_LAST = 16'h0001;

   typedef struct packed {
      logic [15:0] dwell;
      logic [9:0] final_addr;
      logic [9:0] begin_addr;
      logic [2:0] mode;
      logic no_dwell;
   } prs_seg_s;

   // deframed serial port traffic
   typedef struct packed {
      logic instr;
      logic [4:0] addr;
      logic word;
      logic [39:0] data;
   } prs_ser_s;

   // words handed to the synthesizer core
   typedef struct packed {
      logic [31:0] freq;
      logic [13:0] phase;
      logic acc_clear;
   } prs_dds_s;

   typedef enum logic [3:0] {
      PRS_ST_IDLE = 4'b0001,
      PRS_ST_RUN = 4'b0010,
      PRS_ST_HOLD = 4'b0100,
      PRS_ST_ZERO = 4'b1000
   } prs_state_e;

   // address fields are split over discontinuous bit groups
   function automatic prs_seg_s prs_seg_decode(input logic [39:0] w);
      prs_seg_s s;
      s.dwell = w[39:24];
      s.final_addr = {w[9:8], w[23:16]};
      s.begin_addr = {w[3:0], w[15:10]};
      s.mode = w[7:5];
      s.no_dwell = w[4];
      return s;
   endfunction : prs_seg_decode

endpackage : prs_pkg

// ---- logic/prs_sweep_ctrl.sv ----
// prs_sweep_ctrl: profile memory, its loader and the address sequencer feeding the synthesizer core.
// assumes a deframer delivers serial instructions and words as one-cycle pulses, pins synchronous to clk_i.
//
// Summary of operation
// - single-port 1024 by 32 memory, no simultaneous access
// - serial memory write beats and halts reads
// - enable bit routes memory; destination bit picks target
// - destination 0 frequency, 1 phase; registers fill other
// - memory disabled: no reads, loads still accepted
// - reset gives single tone, memory disabled
// - select pins pick segment and its control word
// - memory load suspends reads and sequencing
// - one word per address, beginning to final
// - single tone uses tuning word after update strobe
// - mode 000 outputs beginning address, no stepping
// - profile change swaps word, accumulator keeps phase
// - phase uses upper 14 memory bits only
// - ramp-up loads start, steps on timer expiry
// - ramp-up without no-dwell holds final address
// - no-dwell clears accumulator one dwell after final
// - segment zero bidir mode: pin 0 is direction
// - bidir entry loads beginning and dwell count
// - bidir pin toggles never cause internal update
// - pin high steps up; falling steps down immediately
// - dwell counts sync clocks, one to 65535
// - control word fields: mode, no-dwell, split addresses
`timescale 1ns/100ps
module prs_sweep_ctrl
   import prs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire prs_ser_s ser_i,
   input wire logic io_update_i,
   input wire logic [1:0] segment_select_pins_i,
   output prs_dds_s dds_o,
   output logic [9:0] mem_addr_o,
   output logic load_busy_o,
   output logic [3:0] sweep_state_o
);
   // register file
   logic [31:0] ctrl_buf;
   logic [31:0] ctrl;
   logic [31:0] freq_buf;
   logic [31:0] freq;
   logic [13:0] phase_buf;
   logic [13:0] phase;
   logic [39:0] seg_buf [0:3];
   logic [39:0] seg_act [0:3];
   logic [4:0] cur_addr;
   logic [9:0] load_ptr;
   logic [10:0] load_left;
   logic [31:0] next_ctrl_buf;
   logic [31:0] next_ctrl;
   logic [31:0] next_freq_buf;
   logic [31:0] next_freq;
   logic [13:0] next_phase_buf;
   logic [13:0] next_phase;
   logic [39:0] next_seg_buf [0:3];
   logic [39:0] next_seg_act [0:3];
   logic [4:0] next_cur_addr;
   logic [9:0] next_load_ptr;
   logic [10:0] next_load_left;
   logic next_load_busy;

   // pins and update strobe
   logic upd_q;
   logic upd_d;
   logic [1:0] ps_q;
   logic [1:0] ps_q2;
   logic next_upd_d;

   // sequencer
   prs_state_e state;
   prs_state_e next_state;
   logic [15:0] timer;
   logic [15:0] next_timer;
   logic [9:0] next_mem_addr;
   prs_dds_s next_dds;

   // memory port
   logic mem_we;
   logic mem_re;
   logic [9:0] mem_port_addr;
   logic [31:0] mem_rdata;
   logic mem_rvalid;

   // derived control
   prs_seg_s load_seg;
   prs_seg_s seg;
   prs_seg_s seg0;
   logic mem_en;
   logic mem_dest;
   logic bidir;
   logic ramp;
   logic start;
   logic dir_fall;
   logic expire;

   always_comb begin
      load_seg = prs_seg_decode(seg_buf[ps_q]);
      seg0 = prs_seg_decode(seg_act[0]);
      mem_en = ctrl[PRS_CTRL_MEM_EN_BIT];
      mem_dest = ctrl[PRS_CTRL_MEM_DEST_BIT];
      bidir = mem_en && (seg0.mode == PRS_MODE_BIDIR);
      seg = bidir ? seg0 : prs_seg_decode(seg_act[ps_q]);
      ramp = !bidir && (seg.mode == PRS_MODE_RAMP_UP);
      // pin changes restart a sweep except in bidir, where pin 0 only steers
      start = upd_d || ((ps_q != ps_q2) && !bidir);
      dir_fall = ps_q2[0] && !ps_q[0];
      // a zero dwell is invalid; it behaves like one here
      expire = (timer <= PRS_DWELL_LAST);
   end

   // memory write strobe: only while a load still expects words
   always_comb begin
      // an instruction in the same cycle wins, its word is lost
      mem_we = ser_i.word && !ser_i.instr && (cur_addr == PRS_ADDR_MEM) && load_busy_o;
      mem_re = mem_en && (state != PRS_ST_IDLE) && !load_busy_o && !mem_we;
      mem_port_addr = mem_we ? load_ptr : mem_addr_o;
   end

   // register writes and the buffered-to-active transfer
   always_comb begin
      next_ctrl_buf = ctrl_buf;
      next_freq_buf = freq_buf;
      next_phase_buf = phase_buf;
      next_cur_addr = cur_addr;
      next_load_ptr = load_ptr;
      next_load_left = load_left;
      next_load_busy = load_busy_o;
      for (int i = 0; i < 4; i++) begin
         next_seg_buf[i] = seg_buf[i];
         next_seg_act[i] = seg_act[i];
      end
      if (ser_i.instr) begin
         next_cur_addr = ser_i.addr;
         next_load_busy = 1'b0;
         if (ser_i.addr == PRS_ADDR_MEM) begin
            // load length comes from the segment selected right now
            next_load_ptr = load_seg.begin_addr;
            next_load_left = 11'({1'b0, load_seg.final_addr} - {1'b0, load_seg.begin_addr}) + 11'h001;
            next_load_busy = 1'b1;
         end
      end else if (ser_i.word) begin
         if (cur_addr == PRS_ADDR_CTRL) begin
            next_ctrl_buf = ser_i.data[31:0];
         end else if (cur_addr == PRS_ADDR_FREQ) begin
            next_freq_buf = ser_i.data[31:0];
         end else if (cur_addr == PRS_ADDR_PHASE) begin
            next_phase_buf = ser_i.data[13:0];
         end else if ((cur_addr >= PRS_ADDR_SEG0) && (cur_addr <= PRS_ADDR_SEG3)) begin
            next_seg_buf[2'(cur_addr - PRS_ADDR_SEG0)] = ser_i.data;
         end else if (mem_we) begin
            // consecutive addresses, extra words dropped
            next_load_ptr = load_ptr + 10'h001;
            next_load_left = load_left - 11'h001;
            next_load_busy = (load_left != 11'h001);
         end
      end
      if (upd_q == 1'b0 && io_update_i) begin
         for (int i = 0; i < 4; i++) begin
            next_seg_act[i] = seg_buf[i];
         end
      end
   end

   // scalar buffers move to active on the update edge
   always_comb begin
      next_ctrl = ctrl;
      next_freq = freq;
      next_phase = phase;
      next_upd_d = !upd_q && io_update_i;
      if (next_upd_d) begin
         next_ctrl = ctrl_buf;
         next_freq = freq_buf;
         next_phase = phase_buf;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_buf <= PRS_CTRL_RST;
         ctrl <= PRS_CTRL_RST;
         freq_buf <= PRS_FREQ_RST;
         freq <= PRS_FREQ_RST;
         phase_buf <= PRS_PHASE_RST;
         phase <= PRS_PHASE_RST;
         cur_addr <= PRS_ADDR_CTRL;
         load_ptr <= 10'h000;
         load_left <= 11'h000;
         load_busy_o <= 1'b0;
         upd_q <= 1'b0;
         upd_d <= 1'b0;
         ps_q <= 2'h0;
         ps_q2 <= 2'h0;
         for (int i = 0; i < 4; i++) begin
            seg_buf[i] <= PRS_SEG_RST;
            seg_act[i] <= PRS_SEG_RST;
         end
      end else begin
         ctrl_buf <= next_ctrl_buf;
         ctrl <= next_ctrl;
         freq_buf <= next_freq_buf;
         freq <= next_freq;
         phase_buf <= next_phase_buf;
         phase <= next_phase;
         cur_addr <= next_cur_addr;
         load_ptr <= next_load_ptr;
         load_left <= next_load_left;
         load_busy_o <= next_load_busy;
         upd_q <= io_update_i;
         upd_d <= next_upd_d;
         ps_q <= segment_select_pins_i;
         ps_q2 <= ps_q;
         for (int i = 0; i < 4; i++) begin
            seg_buf[i] <= next_seg_buf[i];
            seg_act[i] <= next_seg_act[i];
         end
      end
   end

   // address sequencer
   always_comb begin
      next_state = state;
      next_timer = timer;
      next_mem_addr = mem_addr_o;
      if (!mem_en) begin
         next_state = PRS_ST_IDLE;
      end else if (load_busy_o) begin
         next_state = state;
      end else if (start) begin
         next_mem_addr = seg.begin_addr;
         next_timer = seg.dwell;
         // direct switch, and the unsupported codes, sit on one address
         next_state = (bidir || ramp) ? PRS_ST_RUN : PRS_ST_HOLD;
      end else begin
         case (state)
            PRS_ST_RUN: begin
               if (bidir) begin
                  if (dir_fall && (mem_addr_o != seg.begin_addr)) begin
                     next_mem_addr = mem_addr_o - 10'h001;
                     next_timer = seg.dwell;
                  end else if (expire) begin
                     next_timer = seg.dwell;
                     if (ps_q[0] && (mem_addr_o != seg.final_addr)) begin
                        next_mem_addr = mem_addr_o + 10'h001;
                     end else if (!ps_q[0] && (mem_addr_o != seg.begin_addr)) begin
                        next_mem_addr = mem_addr_o - 10'h001;
                     end
                  end else begin
                     next_timer = timer - 16'h0001;
                  end
               end else if (mem_addr_o == seg.final_addr) begin
                  if (!seg.no_dwell) begin
                     next_state = PRS_ST_HOLD;
                  end else if (expire) begin
                     next_state = PRS_ST_ZERO;
                  end else begin
                     next_timer = timer - 16'h0001;
                  end
               end else if (expire) begin
                  next_mem_addr = mem_addr_o + 10'h001;
                  next_timer = seg.dwell;
               end else begin
                  next_timer = timer - 16'h0001;
               end
            end
            PRS_ST_HOLD: begin
               next_state = PRS_ST_HOLD;
            end
            PRS_ST_ZERO: begin
               next_state = PRS_ST_ZERO;
            end
            default: begin
               next_state = PRS_ST_IDLE;
            end
         endcase
      end
   end

   // output words: memory word goes one way, a register the other
   always_comb begin
      next_dds.freq = freq;
      next_dds.phase = phase;
      next_dds.acc_clear = 1'b0;
      if (mem_en) begin
         next_dds.acc_clear = (state == PRS_ST_ZERO);
         if (mem_dest) begin
            next_dds.phase = mem_rvalid ? mem_rdata[31:PRS_MEM_PHASE_LSB] : dds_o.phase;
         end else begin
            next_dds.freq = mem_rvalid ? mem_rdata : dds_o.freq;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= PRS_ST_IDLE;
         timer <= PRS_DWELL_LAST;
         mem_addr_o <= 10'h000;
         dds_o <= '0;
         sweep_state_o <= PRS_ST_IDLE;
      end else begin
         state <= next_state;
         timer <= next_timer;
         mem_addr_o <= next_mem_addr;
         dds_o <= next_dds;
         sweep_state_o <= next_state;
      end
   end

   prs_mem u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(mem_we),
      .re_i(mem_re),
      .addr_i(mem_port_addr),
      .wdata_i(ser_i.data[31:0]),
      .rdata_o(mem_rdata),
      .rvalid_o(mem_rvalid)
   );
endmodule : prs_sweep_ctrl

// ---- test/prs_host_model.sv ----
// prs_host_model: host side, driving deframed serial traffic, update pin and select pins.
// assumes tasks are called by the bench; every change lands just after a rising edge.
`timescale 1ns/100ps
module prs_host_model
   import prs_pkg::*;
(
   input wire logic clk_i,
   output prs_ser_s ser_o,
   output logic io_update_o,
   output logic [1:0] pins_o
);
   initial begin
      ser_o <= '0;
      io_update_o <= 1'b0;
      pins_o <= 2'h0;
   end
   function automatic logic [31:0] mw(input logic [9:0] i);
      return {i, 22'h2a5a5};
   endfunction : mw
   task automatic instr(input logic [4:0] a);
      @(posedge clk_i);
      ser_o.instr <= 1'b1;
      ser_o.addr <= a;
      @(posedge clk_i);
      ser_o.instr <= 1'b0;
   endtask : instr
   task automatic wr(input logic [4:0] a, input logic [39:0] d);
      instr(a);
      ser_o.word <= 1'b1;
      ser_o.data <= d;
      @(posedge clk_i);
      ser_o.word <= 1'b0;
      ser_o.data <= ~d; // released data never repeats the last word
   endtask : wr
   // segments are programmed and selected first, begin below final
   task automatic load(input logic [9:0] b, input logic [9:0] f);
      instr(PRS_ADDR_MEM);
      for (int i = b; i <= f + 1; i++) begin
         ser_o.word <= 1'b1;
         ser_o.data <= {8'h00, i > f ? 32'hffff_ffff : mw(10'(i))};
         @(posedge clk_i);
      end
      ser_o.word <= 1'b0;
   endtask : load
   task automatic upd();
      @(posedge clk_i);
      io_update_o <= 1'b1;
      @(posedge clk_i);
      io_update_o <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : upd
   task automatic sel(input logic [1:0] p);
      @(posedge clk_i);
      pins_o <= p;
   endtask : sel
endmodule : prs_host_model

// ---- test/prs_sweep_ctrl_monitor.sv ----
// prs_sweep_ctrl_monitor: port-level assertions for the sweep controller.
// assumes it is bound to prs_sweep_ctrl; one clock, synchronous active-high reset.
`timescale 1ns/100ps
module prs_sweep_ctrl_monitor
   import prs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire prs_ser_s ser_i,
   input wire logic io_update_i,
   input wire logic [1:0] segment_select_pins_i,
   input wire prs_dds_s dds_o,
   input wire logic [9:0] mem_addr_o,
   input wire logic load_busy_o,
   input wire logic [3:0] sweep_state_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // cycles since the last update or pin change; restarts may jump the address
   logic [1:0] pins_q;
   logic [2:0] quiet;
   always_ff @(posedge clk_i) begin
      pins_q <= segment_select_pins_i;
      if (rst_i || io_update_i || segment_select_pins_i != pins_q) begin
         quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
         quiet <= quiet + 3'h1;
      end
   end
   a_reset_values: assert property ($fell(rst_i) |-> sweep_state_o == 4'h1 && dds_o == '0 && mem_addr_o == '0)
      else $error("outputs not at reset values");
   a_load_freeze: assert property (load_busy_o && $past(load_busy_o) |-> $stable(mem_addr_o))
      else $error("address moved during a load");
   a_load_start: assert property ($rose(load_busy_o) |-> $past(ser_i.instr) && $past(ser_i.addr) == PRS_ADDR_MEM)
      else $error("load busy without a memory instruction");
   a_load_end: assert property ($fell(load_busy_o) |-> $past(ser_i.word) || $past(ser_i.instr))
      else $error("load ended without a word");
   a_idle_still: assert property (sweep_state_o == 4'h1 && $past(sweep_state_o) == 4'h1 |-> $stable(mem_addr_o))
      else $error("address moved while memory disabled");
   a_hold_still: assert property (quiet > 3'h3 && sweep_state_o == 4'h4 && $past(sweep_state_o) == 4'h4
      |-> $stable(mem_addr_o)) else $error("address moved in hold");
   a_step_unit: assert property (quiet > 3'h3 && $changed(mem_addr_o) && sweep_state_o == 4'h2
      && $past(sweep_state_o) == 4'h2 |-> mem_addr_o == $past(mem_addr_o) + 10'h1
      || mem_addr_o == $past(mem_addr_o) - 10'h1) else $error("address stepped by more than one");
   a_clear_hold: assert property (sweep_state_o == 4'h8 && $past(sweep_state_o) == 4'h8
      |-> dds_o.acc_clear && $stable(mem_addr_o)) else $error("clear not held at final address");
   a_clear_only: assert property (dds_o.acc_clear |-> sweep_state_o == 4'h8 || $past(sweep_state_o) == 4'h8)
      else $error("accumulator cleared outside final dwell");
endmodule : prs_sweep_ctrl_monitor

bind prs_sweep_ctrl prs_sweep_ctrl_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .ser_i(ser_i),
   .io_update_i(io_update_i), .segment_select_pins_i(segment_select_pins_i), .dds_o(dds_o),
   .mem_addr_o(mem_addr_o), .load_busy_o(load_busy_o), .sweep_state_o(sweep_state_o));

// ---- test/testbench.sv ----
// testbench: single tone, loads, ramp-up, direct switch, no-dwell and bidirectional sweeps.
// assumes prs_host_model on the far side and the bound port monitor.
`timescale 1ns/100ps
module testbench
   import prs_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i;
   prs_ser_s ser;
   logic upd;
   logic [1:0] pins;
   prs_dds_s dds;
   logic [9:0] addr;
   logic busy;
   logic [3:0] st;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   localparam logic [31:0] FW = 32'h1234_5678;
   always #(PRS_CLK_PERIOD_NS / 2) clk_i = ~clk_i;
   prs_sweep_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ser_i(ser), .io_update_i(upd),
      .segment_select_pins_i(pins), .dds_o(dds), .mem_addr_o(addr), .load_busy_o(busy), .sweep_state_o(st));
   prs_host_model host (.clk_i(clk_i), .ser_o(ser), .io_update_o(upd), .pins_o(pins));
   function automatic logic [39:0] seg(input logic [15:0] dw, input logic [9:0] f, input logic [9:0] b,
      input logic [2:0] m, input logic nd);
      return {dw, f[7:0], b[5:0], f[9:8], m, nd, b[9:6]};
   endfunction : seg
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // bounded wait on the address, or on the state when on_st is set
   task automatic wt(input bit on_st, input logic [9:0] v, output int n);
      n = 0;
      while ((on_st ? st !== v[3:0] : addr !== v) && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      chk(on_st ? 32'(st) : 32'(addr), on_st ? 32'(v[3:0]) : 32'(v));
   endtask : wt
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      int n;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(32'(st), 32'h1);
      chk(dds.freq, 32'h0);
      host.wr(PRS_ADDR_FREQ, {8'h00, FW});
      host.wr(PRS_ADDR_PHASE, 40'h0abc);
      @(negedge clk_i);
      chk(dds.freq, 32'h0);
      host.upd();
      repeat (4) @(negedge clk_i);
      chk(dds.freq, FW);
      chk(32'(dds.phase), 32'h0abc);
      $display("test single tone done");
      host.wr(PRS_ADDR_SEG0, seg(16'd3, 10'd7, 10'd4, 3'h1, 1'b0));
      host.wr(PRS_ADDR_SEG1, seg(16'd1, 10'd9, 10'd8, 3'h0, 1'b1));
      host.wr(PRS_ADDR_SEG2, seg(16'd5, 10'd13, 10'd12, 3'h1, 1'b1));
      host.sel(2'h1);
      host.load(10'd8, 10'd9);
      host.sel(2'h0);
      host.load(10'd4, 10'd7);
      host.sel(2'h2);
      host.load(10'd12, 10'd13);
      @(negedge clk_i);
      chk(32'(busy), 32'h0);
      host.sel(2'h0);
      host.wr(PRS_ADDR_CTRL, 40'h0080000000);
      host.upd();
      wt(0, 10'd5, n);
      wt(0, 10'd6, n);
      chk(n, 3);
      wt(0, 10'd7, n);
      repeat (8) @(negedge clk_i);
      chk(32'(addr), 32'd7);
      chk(32'(st), 32'h4);
      chk(dds.freq, host.mw(10'd7));
      host.upd();
      wt(0, 10'd5, n);
      host.load(10'd4, 10'd7);
      @(negedge clk_i);
      chk(32'(addr < 10'd7), 32'h1);
      wt(0, 10'd7, n);
      $display("test ramp up done");
      host.sel(2'h1);
      repeat (8) @(negedge clk_i);
      chk(32'(addr), 32'd8);
      chk(dds.freq, host.mw(10'd8));
      chk(32'(dds.acc_clear), 32'h0);
      host.sel(2'h0);
      wt(0, 10'd4, n);
      host.sel(2'h1);
      host.wr(PRS_ADDR_CTRL, 40'h00c0000000);
      host.upd();
      repeat (6) @(negedge clk_i);
      chk(32'(dds.phase), host.mw(10'd8) >> 18);
      chk(dds.freq, FW);
      $display("test direct switch done");
      host.wr(PRS_ADDR_CTRL, 40'h0080000000);
      host.upd();
      host.sel(2'h2);
      wt(0, 10'd13, n);
      wt(1, 10'h8, n);
      chk(n, 5);
      // the clear output is registered from the state, one cycle behind it
      @(negedge clk_i);
      chk(32'(dds.acc_clear), 32'h1);
      chk(32'(addr), 32'd13);
      $display("test no dwell done");
      host.wr(PRS_ADDR_SEG0, seg(16'd20, 10'd7, 10'd4, 3'h2, 1'b1));
      host.upd();
      repeat (4) @(negedge clk_i);
      chk(32'(addr), 32'd4);
      chk(32'(dds.acc_clear), 32'h0);
      host.sel(2'h3);
      wt(0, 10'd7, n);
      host.wr(PRS_ADDR_PHASE, 40'h1111);
      host.sel(2'h1);
      repeat (30) @(negedge clk_i);
      chk(32'(addr), 32'd7);
      host.sel(2'h0);
      wt(0, 10'd6, n);
      chk(32'(n < 6), 32'h1);
      wt(0, 10'd5, n);
      chk(n, 20);
      wt(0, 10'd4, n);
      repeat (40) @(negedge clk_i);
      chk(32'(addr), 32'd4);
      chk(32'(dds.phase), 32'h0abc);
      chk(dds.freq, host.mw(10'd4));
      $display("test bidirectional done");
      host.wr(PRS_ADDR_CTRL, 40'h0);
      host.upd();
      repeat (4) @(negedge clk_i);
      chk(32'(st), 32'h1);
      chk(dds.freq, FW);
      chk(32'(dds.phase), 32'h1111);
      $display("test memory disabled done");
      end_of_test();
   end
endmodule : testbench
